// ===== hw/tmis_defines.svh
// Register offsets, field positions and reset values of the timer interrupt block
`ifndef TMIS_DEFINES_SVH
`define TMIS_DEFINES_SVH

`define TMIS_ADDR_W        8
`define TMIS_CTL_A_OFF     8'h00
`define TMIS_CTL_B_OFF     8'h04
`define TMIS_LOAD_A_OFF    8'h08
`define TMIS_LOAD_B_OFF    8'h0c
`define TMIS_MASK_OFF      8'h10
`define TMIS_RAW_OFF       8'h14
`define TMIS_MIS_OFF       8'h20
`define TMIS_ICR_OFF       8'h24

`define TMIS_B_XFER_BIT    13
`define TMIS_B_MATCH_BIT   11
`define TMIS_B_CEVT_BIT    10
`define TMIS_B_CMAT_BIT    9
`define TMIS_B_TO_BIT      8
`define TMIS_A_XFER_BIT    5
`define TMIS_A_MATCH_BIT   4
`define TMIS_A_CEVT_BIT    2
`define TMIS_A_CMAT_BIT    1
`define TMIS_A_TO_BIT      0

`define TMIS_FLAG_MASK     32'h00002f37
`define TMIS_MIS_RESET     32'h00000000
`define TMIS_LOAD_RESET    32'hffffffff
`define TMIS_CTL_W         3
`define TMIS_CTL_EN_BIT    0
`define TMIS_CTL_PER_BIT   1
`define TMIS_CTL_UP_BIT    2

`endif

// ===== hw/tmis_pkg.sv
// Shared types of the timer interrupt block
`include "tmis_defines.svh"

package tmis_pkg;

    typedef enum logic [1:0]
    {
        TMIS_CS_IDLE = 2'b00,
        TMIS_CS_RUN  = 2'b01,
        TMIS_CS_DONE = 2'b11
    } tmis_cnt_e;

    typedef struct packed
    {
        logic [31:0]              raw;
        logic [31:0]              mask;
        logic [31:0]              load_a;
        logic [31:0]              load_b;
        logic [`TMIS_CTL_W-1:0]   ctl_a;
        logic [`TMIS_CTL_W-1:0]   ctl_b;
        logic                     lw_a;
        logic                     lw_b;
        logic [31:0]              rdata;
        logic                     irq;
    } tmis_top_s;

endpackage : tmis_pkg

// ===== hw/tmis_cnt_if.sv
// Control and time-out link between the register block and one subtimer counter
interface tmis_cnt_if #(parameter int W = 32);
    logic         enable;
    logic         periodic;
    logic         count_up;
    logic         load_wr;
    logic [W-1:0] load_val;
    logic         timeout;

    modport ctl
    (
        output enable, periodic, count_up, load_wr, load_val,
        input  timeout
    );

    modport cnt
    (
        input  enable, periodic, count_up, load_wr, load_val,
        output timeout
    );
endinterface : tmis_cnt_if

// ===== hw/tmis_counter.sv
// One subtimer counter that pulses time-out when it reaches its limit
module tmis_counter #(
    parameter int W = 32
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    tmis_cnt_if.cnt   c
);
    import tmis_pkg::*;

    typedef struct packed
    {
        tmis_cnt_e    state;
        logic [W-1:0] cnt;
        logic         timeout;
    } tmis_cnt_s;

    tmis_cnt_s q;
    tmis_cnt_s next_q;
    logic      at_limit;
    logic [W-1:0] start_val;

    if (W < 2 || W > 32)
    begin : g_chk
        $error("tmis_counter: W must be 2..32");
    end

    // Down counts end at zero, up counts end at the load value
    assign at_limit  = c.count_up ? (q.cnt == c.load_val) : (q.cnt == '0);
    assign start_val = c.count_up ? '0 : c.load_val;

    always_comb
    begin
        next_q = q;
        next_q.timeout = 1'b0;
        case (q.state)
            TMIS_CS_IDLE:
            begin
                next_q.cnt = start_val;
                if (c.enable)
                    next_q.state = TMIS_CS_RUN;
            end
            TMIS_CS_RUN:
            begin
                if (!c.enable)
                    next_q.state = TMIS_CS_IDLE;
                else if (c.load_wr)
                    next_q.cnt = start_val;
                else if (at_limit)
                begin
                    next_q.timeout = 1'b1;
                    if (c.periodic)
                        next_q.cnt = start_val;
                    else
                        next_q.state = TMIS_CS_DONE;
                end
                else if (c.count_up)
                    next_q.cnt = q.cnt + 1'b1;
                else
                    next_q.cnt = q.cnt - 1'b1;
            end
            TMIS_CS_DONE:
            begin
                if (!c.enable)
                    next_q.state = TMIS_CS_IDLE;
            end
            default:
            begin
                next_q = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            q <= '0;
        else
            q <= next_q;
    end

    assign c.timeout = q.timeout;

    a_timeout_at_limit: assert property (@(posedge clk_sys) disable iff (rst)
        (q.state == TMIS_CS_RUN && c.enable && !c.load_wr && at_limit)
        |=> q.timeout)
        else $error("time-out missing at count limit");

    a_timeout_cause: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(q.timeout) |-> $past(q.state) == TMIS_CS_RUN && $past(at_limit))
        else $error("time-out without reaching the limit");

endmodule : tmis_counter

// ===== hw/tmis_top.sv
// Timer interrupt status block: raw, mask, masked status and clear registers
//
// Added by the designer: strobed register access.
`include "tmis_defines.svh"

module tmis_top #(
    parameter int CNT_W = 32
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic [`TMIS_ADDR_W-1:0] addr,
    input  wire logic [31:0]             wdata,
    input  wire logic                    wr,
    input  wire logic                    rd,
    output logic [31:0]                  rdata,
    output logic                         irq,
    input  wire logic                    a_match_evt,
    input  wire logic                    a_capture_event_evt,
    input  wire logic                    a_capture_match_evt,
    input  wire logic                    a_xfer_done_evt,
    input  wire logic                    b_match_evt,
    input  wire logic                    b_capture_event_evt,
    input  wire logic                    b_capture_match_evt,
    input  wire logic                    b_xfer_done_evt
);
    import tmis_pkg::*;

    tmis_top_s   q;
    tmis_top_s   next_q;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] mis_now;

    tmis_cnt_if #(.W(CNT_W)) cnt_a ();
    tmis_cnt_if #(.W(CNT_W)) cnt_b ();

    if (CNT_W < 2 || CNT_W > 32)
    begin : g_chk
        $error("tmis_top: CNT_W must be 2..32");
    end

    // Masked view, also used for the interrupt output
    function automatic logic [31:0] masked(input logic [31:0] raw,
                                           input logic [31:0] msk);
        masked = raw & msk & `TMIS_FLAG_MASK;
    endfunction : masked

    function automatic logic hit(input logic [`TMIS_ADDR_W-1:0] a,
                                 input logic [`TMIS_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    // Counter controls come from flops so that a load write and the
    // new load value reach the counter in the same cycle
    assign cnt_a.enable   = q.ctl_a[`TMIS_CTL_EN_BIT];
    assign cnt_a.periodic = q.ctl_a[`TMIS_CTL_PER_BIT];
    assign cnt_a.count_up = q.ctl_a[`TMIS_CTL_UP_BIT];
    assign cnt_a.load_wr  = q.lw_a;
    assign cnt_a.load_val = q.load_a[CNT_W-1:0];
    assign cnt_b.enable   = q.ctl_b[`TMIS_CTL_EN_BIT];
    assign cnt_b.periodic = q.ctl_b[`TMIS_CTL_PER_BIT];
    assign cnt_b.count_up = q.ctl_b[`TMIS_CTL_UP_BIT];
    assign cnt_b.load_wr  = q.lw_b;
    assign cnt_b.load_val = q.load_b[CNT_W-1:0];

    tmis_counter #(.W(CNT_W)) u_cnt_a
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .c       (cnt_a.cnt)
    );

    tmis_counter #(.W(CNT_W)) u_cnt_b
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .c       (cnt_b.cnt)
    );

    always_comb
    begin
        set_vec = '0;
        set_vec[`TMIS_B_XFER_BIT]  = b_xfer_done_evt;
        set_vec[`TMIS_B_MATCH_BIT] = b_match_evt;
        set_vec[`TMIS_B_CEVT_BIT]  = b_capture_event_evt;
        set_vec[`TMIS_B_CMAT_BIT]  = b_capture_match_evt;
        set_vec[`TMIS_B_TO_BIT]    = cnt_b.timeout;
        set_vec[`TMIS_A_XFER_BIT]  = a_xfer_done_evt;
        set_vec[`TMIS_A_MATCH_BIT] = a_match_evt;
        set_vec[`TMIS_A_CEVT_BIT]  = a_capture_event_evt;
        set_vec[`TMIS_A_CMAT_BIT]  = a_capture_match_evt;
        set_vec[`TMIS_A_TO_BIT]    = cnt_a.timeout;
    end

    // Only ones clear; zeros and reserved bits are ignored
    assign clr_vec = (wr && hit(addr, `TMIS_ICR_OFF)) ?
                     (wdata & `TMIS_FLAG_MASK) : 32'h00000000;

    assign mis_now = masked(q.raw, q.mask);

    always_comb
    begin
        next_q = q;
        next_q.lw_a = 1'b0;
        next_q.lw_b = 1'b0;
        // A new event wins over a clear in the same cycle
        next_q.raw = ((q.raw & ~clr_vec) | set_vec) & `TMIS_FLAG_MASK;
        if (wr)
        begin
            case (addr)
                `TMIS_CTL_A_OFF:  next_q.ctl_a = wdata[`TMIS_CTL_W-1:0];
                `TMIS_CTL_B_OFF:  next_q.ctl_b = wdata[`TMIS_CTL_W-1:0];
                `TMIS_LOAD_A_OFF:
                begin
                    next_q.load_a = wdata;
                    next_q.lw_a   = 1'b1;
                end
                `TMIS_LOAD_B_OFF:
                begin
                    next_q.load_b = wdata;
                    next_q.lw_b   = 1'b1;
                end
                `TMIS_MASK_OFF:   next_q.mask = wdata & `TMIS_FLAG_MASK;
                // Masked status has no storage of its own, so writes fall away
                default:          next_q.mask = q.mask;
            endcase
        end
        next_q.rdata = 32'h00000000;
        if (rd)
        begin
            case (addr)
                `TMIS_CTL_A_OFF:  next_q.rdata = {29'h0, q.ctl_a};
                `TMIS_CTL_B_OFF:  next_q.rdata = {29'h0, q.ctl_b};
                `TMIS_LOAD_A_OFF: next_q.rdata = q.load_a;
                `TMIS_LOAD_B_OFF: next_q.rdata = q.load_b;
                `TMIS_MASK_OFF:   next_q.rdata = q.mask;
                `TMIS_RAW_OFF:    next_q.rdata = q.raw;
                `TMIS_MIS_OFF:    next_q.rdata = mis_now;
                default:          next_q.rdata = 32'h00000000;
            endcase
        end
        next_q.irq = |masked(next_q.raw, next_q.mask);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            q        <= '0;
            q.raw    <= `TMIS_MIS_RESET;
            q.load_a <= `TMIS_LOAD_RESET;
            q.load_b <= `TMIS_LOAD_RESET;
        end
        else
            q <= next_q;
    end

    assign rdata = q.rdata;
    assign irq   = q.irq;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_reset_clear: assert property (disable iff (1'b0)
        rst
        |=> (mis_now == 32'h0 && !irq && rdata == 32'h0))
        else $error("masked status not zero after reset");

    a_mis_read: assert property (
        (rd && addr == `TMIS_MIS_OFF)
        |=> rdata == $past(mis_now))
        else $error("masked status read does not match raw and mask");

    a_mis_reserved: assert property (
        (rd && addr == `TMIS_MIS_OFF)
        |=> (rdata & ~`TMIS_FLAG_MASK) == 32'h0)
        else $error("reserved masked status bit reads one");

    // Set checks look one cycle on, when the raw flag has landed
    a_b_xfer_masked: assert property (
        b_xfer_done_evt ##1 q.mask[`TMIS_B_XFER_BIT]
        |-> mis_now[`TMIS_B_XFER_BIT] && irq)
        else $error("unmasked B transfer-done not reported");

    a_b_match_set: assert property (
        b_match_evt ##1 q.mask[`TMIS_B_MATCH_BIT]
        |-> mis_now[`TMIS_B_MATCH_BIT] && irq)
        else $error("unmasked B match not reported");

    a_b_cevt_set: assert property (
        b_capture_event_evt ##1 q.mask[`TMIS_B_CEVT_BIT]
        |-> mis_now[`TMIS_B_CEVT_BIT] && irq)
        else $error("unmasked B capture event not reported");

    a_b_cmat_set: assert property (
        b_capture_match_evt ##1 q.mask[`TMIS_B_CMAT_BIT]
        |-> mis_now[`TMIS_B_CMAT_BIT] && irq)
        else $error("unmasked B capture match not reported");

    a_b_timeout_flag: assert property (
        (cnt_b.timeout && q.mask[`TMIS_B_TO_BIT] && !(wr && addr == `TMIS_MASK_OFF))
        |=> mis_now[`TMIS_B_TO_BIT] && irq)
        else $error("B time-out not raised as masked interrupt");

    a_a_xfer_set: assert property (
        a_xfer_done_evt ##1 q.mask[`TMIS_A_XFER_BIT]
        |-> mis_now[`TMIS_A_XFER_BIT] && irq)
        else $error("unmasked A transfer-done not reported");

    a_a_match_set: assert property (
        a_match_evt ##1 q.mask[`TMIS_A_MATCH_BIT]
        |-> mis_now[`TMIS_A_MATCH_BIT] && irq)
        else $error("unmasked A match not reported");

    a_a_match_gated: assert property (
        (rd && addr == `TMIS_MIS_OFF && !q.mask[`TMIS_A_MATCH_BIT])
        |=> !rdata[`TMIS_A_MATCH_BIT])
        else $error("masked A match reads one");

    a_a_cevt_set: assert property (
        a_capture_event_evt ##1 q.mask[`TMIS_A_CEVT_BIT]
        |-> mis_now[`TMIS_A_CEVT_BIT] && irq)
        else $error("unmasked A capture event not reported");

    a_a_cmat_set: assert property (
        a_capture_match_evt ##1 q.mask[`TMIS_A_CMAT_BIT]
        |-> mis_now[`TMIS_A_CMAT_BIT] && irq)
        else $error("unmasked A capture match not reported");

    a_a_timeout_flag: assert property (
        cnt_a.timeout ##1 q.mask[`TMIS_A_TO_BIT]
        |-> mis_now[`TMIS_A_TO_BIT] && irq)
        else $error("A time-out not raised as masked interrupt");

    a_b_clear_bit: assert property (
        (clr_vec[`TMIS_B_XFER_BIT] && !b_xfer_done_evt)
        |=> !q.raw[`TMIS_B_XFER_BIT] && !mis_now[`TMIS_B_XFER_BIT])
        else $error("B transfer-done flag not cleared");

    a_b_match_clear: assert property (
        (clr_vec[`TMIS_B_MATCH_BIT] && !b_match_evt)
        |=> !q.raw[`TMIS_B_MATCH_BIT])
        else $error("B match flag not cleared");

    a_b_cevt_clear: assert property (
        (clr_vec[`TMIS_B_CEVT_BIT] && !b_capture_event_evt)
        |=> !q.raw[`TMIS_B_CEVT_BIT])
        else $error("B capture event flag not cleared");

    a_b_cmat_clear: assert property (
        (clr_vec[`TMIS_B_CMAT_BIT] && !b_capture_match_evt)
        |=> !q.raw[`TMIS_B_CMAT_BIT])
        else $error("B capture match flag not cleared");

    a_b_timeout_clear: assert property (
        (clr_vec[`TMIS_B_TO_BIT] && !cnt_b.timeout)
        |=> !q.raw[`TMIS_B_TO_BIT])
        else $error("B time-out flag not cleared");

    a_a_clear_bit: assert property (
        (wr && addr == `TMIS_ICR_OFF && wdata[`TMIS_A_CEVT_BIT] && !a_capture_event_evt)
        |=> !q.raw[`TMIS_A_CEVT_BIT])
        else $error("A capture event flag not cleared");

    a_a_xfer_clear: assert property (
        (clr_vec[`TMIS_A_XFER_BIT] && !a_xfer_done_evt)
        |=> !q.raw[`TMIS_A_XFER_BIT])
        else $error("A transfer-done flag not cleared");

    a_a_match_clear: assert property (
        (clr_vec[`TMIS_A_MATCH_BIT] && !a_match_evt)
        |=> !q.raw[`TMIS_A_MATCH_BIT])
        else $error("A match flag not cleared");

    a_a_cmat_clear: assert property (
        (clr_vec[`TMIS_A_CMAT_BIT] && !a_capture_match_evt)
        |=> !q.raw[`TMIS_A_CMAT_BIT])
        else $error("A capture match flag not cleared");

    a_a_timeout_clear: assert property (
        (clr_vec[`TMIS_A_TO_BIT] && !cnt_a.timeout)
        |=> !q.raw[`TMIS_A_TO_BIT])
        else $error("A time-out flag not cleared");

    a_zero_no_clear: assert property (
        (wr && addr == `TMIS_ICR_OFF && !wdata[`TMIS_A_MATCH_BIT] && q.raw[`TMIS_A_MATCH_BIT])
        |=> q.raw[`TMIS_A_MATCH_BIT])
        else $error("writing zero cleared a flag");

    // An event in the clear cycle must survive the clear
    a_set_wins: assert property (
        a_match_evt
        |=> q.raw[`TMIS_A_MATCH_BIT])
        else $error("event lost against a clear");

    a_zero_keeps: assert property (
        (wr && addr == `TMIS_ICR_OFF)
        |=> (q.raw & $past(q.raw) & ~$past(wdata)) == ($past(q.raw) & ~$past(wdata)))
        else $error("clear write dropped a flag written as zero");

    a_mis_write_ign: assert property (
        (wr && addr == `TMIS_MIS_OFF && set_vec == 32'h0)
        |=> q.raw == $past(q.raw) && q.mask == $past(q.mask))
        else $error("write to masked status changed a flag");

    a_mask_write: assert property (
        (wr && addr == `TMIS_MASK_OFF)
        |=> q.mask == ($past(wdata) & `TMIS_FLAG_MASK))
        else $error("mask register does not hold the written flag bits");

    a_flags_reserved: assert property (
        ((q.raw | q.mask) & ~`TMIS_FLAG_MASK) == 32'h0)
        else $error("reserved raw or mask bit set");

    a_irq_level: assert property (
        irq == (mis_now != 32'h0))
        else $error("interrupt output disagrees with masked status");

    c_irq_raised: cover property (!irq ##1 irq);
    c_clear_then_low: cover property (irq ##1 (wr && addr == `TMIS_ICR_OFF) ##1 !irq);
    c_set_and_clear: cover property (a_match_evt && clr_vec[`TMIS_A_MATCH_BIT]);
    c_periodic_twice: cover property (cnt_a.timeout ##[1:40] cnt_a.timeout);

endmodule : tmis_top

// ===== tb/tb_timer_masked_irq_status.sv
// Self-checking bench for the timer masked interrupt status block
`include "tmis_defines.svh"

module tb_timer_masked_irq_status;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    clk_sys     = 1'b0;
    logic                    rst         = 1'b1;
    logic [`TMIS_ADDR_W-1:0] addr        = '0;
    logic [31:0]             wdata       = '0;
    logic                    wr          = 1'b0;
    logic                    rd          = 1'b0;
    logic [31:0]             rdata;
    logic                    irq;
    logic [7:0]              evt         = '0;
    logic [31:0]             m_raw       = '0;
    logic [31:0]             m_mask      = '0;
    logic [31:0]             rd_val;
    int                      miscompares = 0;
    int                      num_checks  = 0;
    int                      cycles      = 0;
    int                      evt_pos[8]  = '{4, 2, 1, 5, 11, 10, 9, 13};

    always #4 clk_sys = ~clk_sys;

    // Short counter width keeps the time-out runs brief
    tmis_top #(.CNT_W(4)) dut_u
    (
        .clk_sys             (clk_sys),
        .rst                 (rst),
        .addr                (addr),
        .wdata               (wdata),
        .wr                  (wr),
        .rd                  (rd),
        .rdata               (rdata),
        .irq                 (irq),
        .a_match_evt         (evt[0]),
        .a_capture_event_evt (evt[1]),
        .a_capture_match_evt (evt[2]),
        .a_xfer_done_evt     (evt[3]),
        .b_match_evt         (evt[4]),
        .b_capture_event_evt (evt[5]),
        .b_capture_match_evt (evt[6]),
        .b_xfer_done_evt     (evt[7])
    );

    function automatic logic [31:0] to_flags(input logic [7:0] e);
        logic [31:0] f;
        f = '0;
        for (int i = 0; i < 8; i++)
        begin
            f[evt_pos[i]] = e[i];
        end
        return f;
    endfunction : to_flags

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic bus_wr(input logic [`TMIS_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
        if (a == `TMIS_MASK_OFF)
            m_mask = d & `TMIS_FLAG_MASK;
        if (a == `TMIS_ICR_OFF)
            m_raw = m_raw & ~d;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [`TMIS_ADDR_W-1:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1;
        rd_val = rdata;
    endtask : bus_rd

    task automatic check_mis(input string name);
        bus_rd(`TMIS_MIS_OFF);
        chk(name, rd_val, m_raw & m_mask);
        chk("irq", {31'h0, irq}, {31'h0, |(m_raw & m_mask)});
    endtask : check_mis

    task automatic pulse(input logic [7:0] e);
        @(posedge clk_sys);
        evt <= e;
        @(posedge clk_sys);
        evt <= '0;
        m_raw = m_raw | to_flags(e);
    endtask : pulse

    // Counter latency is the design's, so poll under a bound
    task automatic wait_timeout(input int b);
        int n;
        n = 0;
        bus_rd(`TMIS_RAW_OFF);
        while (rd_val[b] !== 1'b1 && n < 40)
        begin
            bus_rd(`TMIS_RAW_OFF);
            n++;
        end
        chk("timeout raw", rd_val & 32'h101, 32'h1 << b);
        m_raw[b] = 1'b1;
    endtask : wait_timeout

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial
    begin
        void'($urandom(94));
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;

        check_mis("mis after reset");
        bus_rd(`TMIS_RAW_OFF);
        chk("raw after reset", rd_val, 32'h0);
        $display("test reset done");

        bus_wr(`TMIS_MASK_OFF, 32'hffffffff);
        bus_rd(`TMIS_MASK_OFF);
        chk("mask readback", rd_val, `TMIS_FLAG_MASK);
        for (int i = 0; i < 8; i++)
        begin
            pulse(8'h1 << i);
            check_mis("mis one flag");
            bus_wr(`TMIS_ICR_OFF, ~to_flags(8'h1 << i));
            check_mis("mis zero clear");
            bus_wr(`TMIS_MIS_OFF, 32'hffffffff);
            check_mis("mis after write");
            bus_wr(`TMIS_ICR_OFF, to_flags(8'h1 << i));
            check_mis("mis after clear");
        end
        bus_wr(`TMIS_MASK_OFF, 32'h0);
        pulse(8'hff);
        check_mis("mis all masked");
        bus_rd(`TMIS_RAW_OFF);
        chk("raw while masked", rd_val, to_flags(8'hff));
        bus_wr(`TMIS_MASK_OFF, 32'hffffffff);
        check_mis("mis unmasked late");
        bus_wr(`TMIS_ICR_OFF, 32'hffffffff);
        check_mis("mis all cleared");
        // Event and clear in one cycle: the event must survive
        pulse(8'h03);
        @(posedge clk_sys);
        evt   <= 8'h01;
        addr  <= `TMIS_ICR_OFF;
        wdata <= to_flags(8'h03);
        wr    <= 1'b1;
        @(posedge clk_sys);
        evt <= '0;
        wr  <= 1'b0;
        m_raw = (m_raw & ~to_flags(8'h03)) | to_flags(8'h01);
        check_mis("mis set wins");
        bus_wr(`TMIS_ICR_OFF, 32'hffffffff);
        check_mis("mis set wins cleared");
        $display("test flags done");

        bus_wr(`TMIS_LOAD_A_OFF, 32'h2);
        bus_wr(`TMIS_CTL_A_OFF, 32'h1);
        wait_timeout(0);
        check_mis("mis timeout a");
        bus_wr(`TMIS_ICR_OFF, 32'h1);
        check_mis("mis timeout a clear");
        repeat (20) @(posedge clk_sys);
        bus_rd(`TMIS_RAW_OFF);
        chk("one shot stopped", rd_val, 32'h0);
        bus_wr(`TMIS_CTL_A_OFF, 32'h0);
        bus_wr(`TMIS_LOAD_B_OFF, 32'h3);
        bus_wr(`TMIS_CTL_B_OFF, 32'h5);
        wait_timeout(8);
        check_mis("mis timeout b");
        bus_wr(`TMIS_CTL_B_OFF, 32'h0);
        bus_wr(`TMIS_ICR_OFF, 32'h100);
        check_mis("mis timeout b clear");
        // Periodic down count must time out again after a clear
        bus_wr(`TMIS_LOAD_A_OFF, 32'h2);
        bus_wr(`TMIS_CTL_A_OFF, 32'h3);
        wait_timeout(0);
        bus_wr(`TMIS_ICR_OFF, 32'h1);
        wait_timeout(0);
        bus_wr(`TMIS_CTL_A_OFF, 32'h0);
        bus_wr(`TMIS_ICR_OFF, 32'h1);
        check_mis("mis periodic stopped");
        $display("test timeouts done");

        // Random masks, events and clears, with stray writes to the status
        for (int k = 0; k < 40; k++)
        begin
            bus_wr(`TMIS_MASK_OFF, $urandom());
            pulse(8'($urandom()));
            check_mis("mis random");
            bus_wr(`TMIS_MIS_OFF, $urandom());
            bus_wr(`TMIS_ICR_OFF, $urandom());
            check_mis("mis random clear");
        end
        // Mid-run reset must drop every flag and the mask
        bus_wr(`TMIS_MASK_OFF, 32'hffffffff);
        pulse(8'hff);
        check_mis("mis before mid reset");
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        m_raw  = '0;
        m_mask = '0;
        check_mis("mis after mid reset");
        bus_rd(`TMIS_RAW_OFF);
        chk("raw after mid reset", rd_val, 32'h0);
        bus_rd(8'h40);
        chk("unmapped read", rd_val, 32'h0);
        $display("test random done");
        tally_and_finish();
    end
endmodule : tb_timer_masked_irq_status
